/* sca_host_model.sv */
// Purpose: Host controller stand-in, a classic Wishbone master
// Assumes: Slave answers with a registered one-cycle ack
// Notes: Released write data is inverted so a stale value never passes
`timescale 1ns/1ps
module sca_host_model
(
  input wire logic i_ref_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_dat,
  output sca_pkg::sca_wb_req_t o_req
);
  import sca_pkg::*;
  initial o_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit to);
    int n;
    @(posedge i_ref_clk);
    o_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    n = 0;
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end
    while (i_ack !== 1'b1 && n < 16);
    to = (i_ack !== 1'b1);
    q = i_dat;
    o_req <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, sel: 4'h0, adr: a, dat: ~d};
  endtask
endmodule // sca_host_model

/* sca_pkg.sv */
// Purpose: Constants and types for the secure configuration access block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Fuse and password state are modelled as flops initialised by reset
package sca_pkg;
  // Register byte offsets
  localparam logic [7:0] SCA_CMD_OFS = 8'h00;
  localparam logic [7:0] SCA_DLO_OFS = 8'h04;
  localparam logic [7:0] SCA_DHI_OFS = 8'h08;
  localparam logic [7:0] SCA_CFG_OFS = 8'h0c;
  localparam logic [7:0] SCA_STAT_OFS = 8'h10;
  localparam logic [7:0] SCA_AAC_OFS = 8'h14;
  localparam logic [7:0] SCA_PAC_OFS = 8'h20;
  // Command and check fields
  localparam int SCA_OP_LSB = 0;
  localparam int SCA_IDX_LSB = 4;
  localparam int SCA_ZONE_LSB = 0;
  localparam int SCA_RW_BIT = 4;
  localparam int SCA_SET_LSB = 5;
  localparam int SCA_ZR_RD_BIT = 8;
  localparam int SCA_ZR_WR_BIT = 9;
  // Fuse bit positions (0 means blown)
  localparam int SCA_FAB = 0;
  localparam int SCA_CMA = 1;
  localparam int SCA_PER = 2;
  localparam int SCA_LOT = 3;
  // Reset values, counter lock level and secure code index
  localparam logic [3:0] SCA_FUSE_RST = 4'hf;
  localparam logic [7:0] SCA_CNT_FULL = 8'hff;
  localparam logic [7:0] SCA_CNT_LOCK = 8'h00;
  localparam logic [23:0] SCA_PW_RST = 24'hffffff;
  localparam logic [23:0] SCA_SC_RST = 24'h5a5a5a; // Arbitrary value
  localparam logic [3:0] SCA_SC_IDX = 4'hf;
  localparam logic SCA_ETA_RST = 1'b1;

  typedef enum logic [2:0] {
    OP_VERIFY, OP_AUTH, OP_ENCV, OP_BLOW, OP_WRPW, OP_WRSEED, OP_WRPAC, OP_CHECK
  } sca_op_t;

  typedef enum logic [3:0] {
    ZN_IDENT, ZN_MTZ, ZN_CMC, ZN_LOT, ZN_ACC, ZN_CRYPTO, ZN_SKEY,
    ZN_SECRET, ZN_PW, ZN_PAC, ZN_FORBID, ZN_USER
  } sca_zone_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_REPORT} sca_st_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } sca_wb_req_t;

  typedef struct packed {
    sca_st_t st;
    logic ack;
    logic [31:0] rdat;
    sca_op_t op;
    logic [3:0] idx;
    logic [31:0] lo;
    logic [31:0] hi;
    logic eta_n;
    logic [3:0] fuse;
    logic [15:0][23:0] pw;
    logic [15:0][7:0] password_trial_count;
    logic [3:0][7:0] aac;
    logic [3:0][63:0] seed;
    logic [3:0][63:0] skey;
    logic sec_ok;
    logic wr_ok;
    logic [2:0] wr_set;
    logic pend_ok;
    logic pend_lock;
    logic ok;
    logic lock;
  } sca_state_t;
endpackage

/* sca_top.sv */
// Purpose: Security state, trial counters, fuses and config access rights
// Assumes: Crypto engine outside reports auth pass/fail in DATA_LO bit 0
// Notes: Commands take three cycles; result stands in STATUS afterwards
// Functional notes
// - Four 64-bit session keys, updated after each good auth or encryption check.
// - Session keys need no initial programming to work.
// - Four 64-bit secret seeds, each mixed with its own session key.
// - Eight password sets, each a 24-bit read and 24-bit write password.
// - Write password verified allows changing both passwords of that set; before final lock the secure code allows any set.
// - Set 7 write password is the secure code, opening config writes.
// - Secure code changes only after it has been verified.
// - Final lock blown: secure code no longer opens config writes.
// - Sixteen 8-bit password counters limit wrong tries to four.
// - Wrong password steps counter FF, EE, CC, 88, 00.
// - Counter at 00 refuses that password until OP_WRPAC rewrites the counter.
// - Correct password while counter nonzero restores it to FF.
// - Four 8-bit auth counters limit failed authentications to four.
// - Failed auth steps FF, EE, CC, 88, 00; 00 locks key set.
// - Good auth while counter nonzero restores it to FF.
// - Fuse byte: bit3 lot, bit2 final, bit1 maker, bit0 factory; 0 blown.
// - A blown fuse never returns by any command.
// - Fuses blow factory, then maker, then final; out of order is rejected.
// - Factory, maker and final fuses each freeze their own configuration areas; the lot fuse freezes none.
// - Lot history code is never writable.
// - Before final lock, secure code gates secret and password areas; after, write password gates password areas only.
// - Forbidden areas deny all reads and writes.
// - User zones follow only their zone rights.
// - Extended trials allow eight failures, clearing one bit each time.
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module sca_top
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat
);
  import sca_pkg::*;

  sca_state_t q;
  sca_state_t d;
  sca_wb_req_t req;
  logic pw_match;
  logic [7:0] cnt_cur;
  logic [7:0] cnt_step;
  logic grant;
  sca_zone_t zone;
  logic zrw;
  logic [2:0] zset;
  logic pre_per;

  assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel,
                 adr: i_wb_adr, dat: i_wb_dat};

  // Four-trial mode clears a bit in each nibble; eight-trial mode one bit
  function automatic logic [7:0] step(input logic [7:0] c, input logic eta_n);
    if (eta_n)
    begin
      step = {c[6:4], 1'b0, c[2:0], 1'b0};
    end
    else
    begin
      step = {c[6:0], 1'b0};
    end
  endfunction

  assign pre_per = q.fuse[SCA_PER];
  assign pw_match = (q.pw[q.idx] == q.lo[23:0]);
  assign cnt_cur = (q.op == OP_AUTH) ? q.aac[q.idx[1:0]] : q.password_trial_count[q.idx];
  assign cnt_step = step(cnt_cur, q.eta_n);
  assign zone = sca_zone_t'(q.lo[SCA_ZONE_LSB +: 4]);
  assign zrw = q.lo[SCA_RW_BIT];
  assign zset = q.lo[SCA_SET_LSB +: 3];

  // Config area rights per fuse state; zrw high asks for a write
  always_comb
  begin
    grant = 1'b0;
    case (zone)
      ZN_IDENT:
        grant = !zrw || (q.sec_ok && q.fuse[SCA_FAB]);
      ZN_MTZ:
        grant = 1'b1;
      ZN_CMC:
        grant = !zrw || (q.sec_ok && q.fuse[SCA_CMA]);
      ZN_LOT:
        grant = !zrw;
      ZN_ACC, ZN_CRYPTO:
        grant = !zrw || (q.sec_ok && pre_per);
      ZN_SKEY, ZN_SECRET:
        grant = q.sec_ok && pre_per;
      ZN_PW:
        grant = pre_per ? q.sec_ok : (q.wr_ok && q.wr_set == zset);
      ZN_PAC:
        grant = !zrw || (pre_per ? q.sec_ok : (q.wr_ok && q.wr_set == zset));
      ZN_USER:
        grant = zrw ? q.lo[SCA_ZR_WR_BIT] : q.lo[SCA_ZR_RD_BIT];
      default:
        grant = 1'b0;
    endcase
  end

  always_comb
  begin
    logic wr_hit;
    logic set_ok;
    wr_hit = 1'b0;
    set_ok = 1'b0;
    d = q;
    d.ack = 1'b0;
    // Bus side: one wait state, ack for exactly one cycle
    if (req.cyc && req.stb && !q.ack)
    begin
      d.ack = 1'b1;
      d.rdat = '0;
      wr_hit = req.we;
      case (req.adr)
        SCA_DLO_OFS: d.rdat = q.lo;
        SCA_DHI_OFS: d.rdat = q.hi;
        SCA_CFG_OFS: d.rdat = {31'h0, q.eta_n};
        SCA_STAT_OFS: d.rdat = {16'h0, q.wr_set, q.wr_ok, q.sec_ok, q.lock,
                                q.ok, (q.st != ST_IDLE), 4'h0, q.fuse};
        SCA_AAC_OFS: d.rdat = q.aac;
        SCA_PAC_OFS: d.rdat = q.password_trial_count[3:0];
        SCA_PAC_OFS + 8'h04: d.rdat = q.password_trial_count[7:4];
        SCA_PAC_OFS + 8'h08: d.rdat = q.password_trial_count[11:8];
        SCA_PAC_OFS + 8'h0c: d.rdat = q.password_trial_count[15:12];
        default: d.rdat = '0;
      endcase
    end
    if (wr_hit)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (req.sel[b] && req.adr == SCA_DLO_OFS && q.st == ST_IDLE)
        begin
          d.lo[b*8 +: 8] = req.dat[b*8 +: 8];
        end
        if (req.sel[b] && req.adr == SCA_DHI_OFS && q.st == ST_IDLE)
        begin
          d.hi[b*8 +: 8] = req.dat[b*8 +: 8];
        end
      end
      if (req.adr == SCA_CFG_OFS && req.sel[0])
      begin
        d.eta_n = req.dat[0];
      end
      // Commands while busy are dropped; software polls the busy bit
      if (req.adr == SCA_CMD_OFS && req.sel[0] && q.st == ST_IDLE)
      begin
        d.op = sca_op_t'(req.dat[SCA_OP_LSB +: 3]);
        d.idx = req.dat[SCA_IDX_LSB +: 4];
        d.st = ST_EXEC;
      end
    end
    case (q.st)
      ST_IDLE:
        begin
        end
      ST_EXEC:
        begin
          d.st = ST_REPORT;
          d.pend_ok = 1'b0;
          d.pend_lock = 1'b0;
          set_ok = q.wr_ok && q.wr_set == q.idx[3:1];
          case (q.op)
            OP_VERIFY:
              if (q.password_trial_count[q.idx] == SCA_CNT_LOCK)
              begin
                d.pend_lock = 1'b1;
              end
              else if (pw_match)
              begin
                d.password_trial_count[q.idx] = SCA_CNT_FULL;
                d.pend_ok = 1'b1;
                if (q.idx[0])
                begin
                  d.wr_ok = 1'b1;
                  d.wr_set = q.idx[3:1];
                  d.sec_ok = (q.idx == SCA_SC_IDX) && pre_per;
                end
              end
              else
              begin
                d.password_trial_count[q.idx] = cnt_step;
              end
            OP_AUTH:
              if (q.aac[q.idx[1:0]] == SCA_CNT_LOCK)
              begin
                d.pend_lock = 1'b1;
              end
              else if (q.lo[0])
              begin
                d.aac[q.idx[1:0]] = SCA_CNT_FULL;
                d.skey[q.idx[1:0]] = {q.skey[q.idx[1:0]][62:0],
                                      q.skey[q.idx[1:0]][63]}
                                     ^ q.seed[q.idx[1:0]];
                d.pend_ok = 1'b1;
              end
              else
              begin
                d.aac[q.idx[1:0]] = cnt_step;
              end
            OP_ENCV:
              if (q.lo[0])
              begin
                d.skey[q.idx[1:0]] = {q.skey[q.idx[1:0]][62:0],
                                      q.skey[q.idx[1:0]][63]}
                                     ^ q.seed[q.idx[1:0]];
                d.pend_ok = 1'b1;
              end
            OP_BLOW:
              begin
                // Fuses only clear; a set bit is never written back
                case (q.idx[1:0])
                  2'd0: d.pend_ok = 1'b1;
                  2'd1: d.pend_ok = !q.fuse[SCA_FAB];
                  2'd2: d.pend_ok = !q.fuse[SCA_CMA];
                  default: d.pend_ok = 1'b1;
                endcase
                if (d.pend_ok)
                begin
                  d.fuse[q.idx[1:0]] = 1'b0;
                end
              end
            OP_WRPW:
              if (pre_per ? (q.sec_ok || set_ok) : set_ok)
              begin
                d.pw[q.idx] = q.lo[23:0];
                d.pend_ok = 1'b1;
              end
            OP_WRSEED:
              if (q.sec_ok && pre_per)
              begin
                d.seed[q.idx[1:0]] = {q.hi, q.lo};
                d.pend_ok = 1'b1;
              end
            OP_WRPAC:
              if (pre_per ? q.sec_ok : set_ok)
              begin
                d.password_trial_count[q.idx] = q.lo[7:0];
                d.pend_ok = 1'b1;
              end
            default:
              d.pend_ok = grant;
          endcase
        end
      ST_REPORT:
        begin
          d.ok = q.pend_ok;
          d.lock = q.pend_lock;
          d.st = ST_IDLE;
        end
      default:
        d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    // Reset stands for power-up of a fresh part; no command restores a fuse
    if (i_srst)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.op <= OP_VERIFY;
      q.eta_n <= SCA_ETA_RST;
      q.fuse <= SCA_FUSE_RST;
      q.password_trial_count <= {16{SCA_CNT_FULL}};
      q.aac <= {4{SCA_CNT_FULL}};
      q.pw <= {SCA_SC_RST, {15{SCA_PW_RST}}};
    end
    else
    begin
      q <= d;
    end
  end

  assign o_wb_ack = q.ack;
  assign o_wb_dat = q.rdat;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  property p_ack_pulse;
    q.ack |=> !q.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_fuse_keep;
    1'b1 |=> ((q.fuse & ~$past(q.fuse)) == 4'h0);
  endproperty
  a_fuse_keep: assert property (p_fuse_keep) else $error("fuse restored");

  property p_cma_order;
    $fell(q.fuse[SCA_CMA]) |-> !q.fuse[SCA_FAB];
  endproperty
  a_cma_order: assert property (p_cma_order) else $error("maker lock before factory");

  property p_per_order;
    $fell(q.fuse[SCA_PER]) |-> !q.fuse[SCA_CMA];
  endproperty
  a_per_order: assert property (p_per_order) else $error("final lock out of order");

  property p_pac_locked;
    (q.st == ST_EXEC && q.op == OP_VERIFY && q.password_trial_count[q.idx] == SCA_CNT_LOCK)
      |=> q.password_trial_count[$past(q.idx)] == SCA_CNT_LOCK ##1 q.lock;
  endproperty
  a_pac_locked: assert property (p_pac_locked) else $error("locked pw counter moved");

  property p_pac_restore;
    (q.st == ST_EXEC && q.op == OP_VERIFY && q.password_trial_count[q.idx] != 8'h00 && pw_match)
      |=> q.password_trial_count[$past(q.idx)] == 8'hff ##1 q.ok;
  endproperty
  a_pac_restore: assert property (p_pac_restore) else $error("pw counter not restored");

  property p_pac_step4;
    (q.st == ST_EXEC && q.op == OP_VERIFY && q.password_trial_count[q.idx] == 8'hee && !pw_match
      && q.eta_n) |=> q.password_trial_count[$past(q.idx)] == 8'hcc;
  endproperty
  a_pac_step4: assert property (p_pac_step4) else $error("pw counter step wrong");

  property p_report_after;
    (q.st == ST_EXEC) |=> (q.st == ST_REPORT) ##1 (q.st == ST_IDLE);
  endproperty
  a_report_after: assert property (p_report_after) else $error("result not after commit");

  property p_per_no_cfg;
    (q.st == ST_EXEC && q.op == OP_CHECK && !q.fuse[SCA_PER] && zrw
      && (zone == ZN_ACC || zone == ZN_CRYPTO)) |=> ##1 !q.ok;
  endproperty
  a_per_no_cfg: assert property (p_per_no_cfg) else $error("config write after final lock");

  // Keys are not readable, so their update is only watched here
  property p_skey_hold;
    !(q.st == ST_EXEC && (q.op == OP_AUTH || q.op == OP_ENCV) && q.lo[0])
      |=> q.skey == $past(q.skey);
  endproperty
  a_skey_hold: assert property (p_skey_hold) else $error("session key moved");

  property p_aac_locked;
    (q.st == ST_EXEC && q.op == OP_AUTH && q.aac[q.idx[1:0]] == SCA_CNT_LOCK)
      |=> q.aac[$past(q.idx[1:0])] == SCA_CNT_LOCK ##1 q.lock;
  endproperty
  a_aac_locked: assert property (p_aac_locked) else $error("auth key set unlocked");

  property p_aac_restore;
    (q.st == ST_EXEC && q.op == OP_AUTH && q.aac[q.idx[1:0]] != SCA_CNT_LOCK && q.lo[0])
      |=> q.aac[$past(q.idx[1:0])] == SCA_CNT_FULL ##1 q.ok;
  endproperty
  a_aac_restore: assert property (p_aac_restore) else $error("auth count not reset");

  property p_pac_step8;
    (q.st == ST_EXEC && q.op == OP_VERIFY && q.password_trial_count[q.idx] == 8'hfe && !pw_match
      && !q.eta_n) |=> q.password_trial_count[$past(q.idx)] == 8'hfc;
  endproperty
  a_pac_step8: assert property (p_pac_step8) else $error("8-trial step wrong");

  property p_seed_lock;
    (q.st == ST_EXEC && q.op == OP_WRSEED && !pre_per) |=> q.seed == $past(q.seed);
  endproperty
  a_seed_lock: assert property (p_seed_lock) else $error("seed written after lock");

  property p_lot_ro;
    (q.st == ST_EXEC && q.op == OP_CHECK && zone == ZN_LOT && zrw) |=> ##1 !q.ok;
  endproperty
  a_lot_ro: assert property (p_lot_ro) else $error("lot code write granted");

  property p_forbid;
    (q.st == ST_EXEC && q.op == OP_CHECK && zone == ZN_FORBID) |=> ##1 !q.ok;
  endproperty
  a_forbid: assert property (p_forbid) else $error("forbidden area granted");
endmodule // sca_top

/* tb_sca_top.sv */
// Purpose: Self-checking bench for the security state block
// Assumes: Host model issues every bus cycle
// Notes: Counter expectations are tracked in a local array
`timescale 1ns/1ps
module tb_sca_top;
  import sca_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  sca_wb_req_t req;
  logic ack;
  logic [31:0] rdat;
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] cnt_exp [20];
  always #12.5 i_ref_clk = ~i_ref_clk;
  sca_top dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_wb_cyc(req.cyc), .i_wb_stb(req.stb),
    .i_wb_we(req.we), .i_wb_sel(req.sel), .i_wb_adr(req.adr), .i_wb_dat(req.dat),
    .o_wb_ack(ack), .o_wb_dat(rdat));
  sca_host_model host (.i_ref_clk(i_ref_clk), .i_ack(ack), .i_dat(rdat), .o_req(req));

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    bit to;
    host.xfer(w, a, d, q, to);
    if (to)
    begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic cmd(input logic [2:0] op, input logic [3:0] idx, input logic [31:0] lo,
                     output logic [31:0] st);
    int n;
    bus(1'b1, SCA_DLO_OFS, lo, st);
    bus(1'b1, SCA_CMD_OFS, {24'h0, idx, 1'b0, op}, st);
    n = 0;
    do
    begin
      bus(1'b0, SCA_STAT_OFS, 32'h0, st);
      n++;
    end
    while (st[8] !== 1'b0 && n < 8);
    if (st[8] !== 1'b0)
    begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic acc(input logic [31:0] lo, input logic exp);
    logic [31:0] st;
    cmd(OP_CHECK, 4'h0, lo, st);
    chk("access", 32'(st[9]), 32'(exp));
  endtask

  task automatic blow(input logic [3:0] f, input logic [3:0] fz, output logic [31:0] st);
    cmd(OP_BLOW, f, 32'h0, st);
    chk("fuses", 32'(st[7:0]), 32'(fz));
  endtask

  // Four-trial mode clears a bit in each nibble; eight-trial mode clears one bit
  function automatic logic [7:0] step(input logic [7:0] c, input logic eta_n);
    if (!eta_n)
      return {c[6:0], 1'b0};
    case (c)
      8'hff: return 8'hee;
      8'hee: return 8'hcc;
      8'hcc: return 8'h88;
      default: return 8'h00;
    endcase
  endfunction

  initial
  begin
    logic [31:0] q;
    logic [31:0] st;
    logic [31:0] lo;
    logic [3:0] i;
    logic good;
    logic live;
    int k;
    void'($urandom(32'h50749957));
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    foreach (cnt_exp[j]) cnt_exp[j] = SCA_CNT_FULL;
    bus(1'b0, SCA_STAT_OFS, 32'h0, q);
    chk("fuse byte", 32'(q[7:0]), 32'h0f);
    bus(1'b0, SCA_AAC_OFS, 32'h0, q);
    chk("auth counters", q, 32'hffffffff);
    for (int r = 0; r < 4; r++)
    begin
      bus(1'b0, SCA_PAC_OFS + 8'(4 * r), 32'h0, q);
      chk("password counters", q, 32'hffffffff);
    end
    $display("test reset done");
    // First five tries of each kind force a lockout, then random traffic
    for (int p = 0; p < 2; p++)
      for (int t = 0; t < 40; t++)
      begin
        i = t < 5 ? 4'(p) : 4'($urandom_range(p ? 3 : 13));
        good = t < 5 ? (t == 4) : 1'($urandom_range(1));
        k = p ? 16 + i[1:0] : i;
        live = cnt_exp[k] != 8'h00;
        lo = p ? 32'(good) : (good ? 32'h00ffffff : 32'($urandom) & 32'h007fffff);
        cmd(p ? OP_AUTH : OP_VERIFY, i, lo, st);
        chk("ok", 32'(st[9]), 32'(good && live));
        chk("lock", 32'(st[10]), 32'(!live));
        cnt_exp[k] = !live ? 8'h00 : good ? 8'hff : step(cnt_exp[k], 1'b1);
        bus(1'b0, p ? SCA_AAC_OFS : SCA_PAC_OFS + {4'h0, i[3:2], 2'b00}, 32'h0, q);
        chk("counter", 32'(q[{i[1:0], 3'b000} +: 8]), 32'(cnt_exp[k]));
      end
    $display("test counters done");
    bus(1'b1, SCA_CFG_OFS, 32'h0, q);
    repeat (2)
    begin
      cmd(OP_VERIFY, 4'he, 32'h0, st);
      cnt_exp[14] = step(cnt_exp[14], 1'b0);
      bus(1'b0, SCA_PAC_OFS + 8'h0c, 32'h0, q);
      chk("extended counter", 32'(q[23:16]), 32'(cnt_exp[14]));
    end
    $display("test extended trials done");
    blow(4'h2, 4'hf, st);
    chk("blow final early", 32'(st[9]), 32'h0);
    blow(4'h1, 4'hf, st);
    chk("blow maker early", 32'(st[9]), 32'h0);
    blow(4'h0, 4'he, st);
    chk("blow factory", 32'(st[9]), 32'h1);
    cmd(OP_WRPW, SCA_SC_IDX, 32'h00111111, st);
    chk("secure code refused", 32'(st[9]), 32'h0);
    cmd(OP_VERIFY, SCA_SC_IDX, 32'(SCA_SC_RST), st);
    chk("secure code kept", 32'(st[11]), 32'h1);
    cmd(OP_WRPW, SCA_SC_IDX, 32'h00123456, st);
    cmd(OP_VERIFY, SCA_SC_IDX, 32'h00123456, st);
    chk("secure code changed", 32'(st[11]), 32'h1);
    cmd(OP_WRPAC, 4'h3, 32'h000000ab, st);
    chk("counter write ok", 32'(st[9]), 32'h1);
    cnt_exp[3] = 8'hab;
    bus(1'b0, SCA_PAC_OFS, 32'h0, q);
    chk("written counter", 32'(q[31:24]), 32'(cnt_exp[3]));
    cmd(OP_WRSEED, 4'h1, 32'h00000001, st);
    chk("seed write", 32'(st[9]), 32'h1);
    cmd(OP_ENCV, 4'h1, 32'h0, st);
    chk("encryption fail", 32'(st[9]), 32'h0);
    cmd(OP_ENCV, 4'h1, 32'h1, st);
    chk("encryption pass", 32'(st[9]), 32'h1);
    acc(32'h12, 1'b1);
    acc(32'h10, 1'b0);
    acc(32'h14, 1'b1);
    acc(32'h13, 1'b0);
    acc(32'h0a, 1'b0);
    acc(32'h10b, 1'b1);
    acc(32'h21b, 1'b1);
    acc(32'h01b, 1'b0);
    blow(4'h1, 4'hc, st);
    acc(32'h12, 1'b0);
    blow(4'h2, 4'h8, st);
    cmd(OP_VERIFY, SCA_SC_IDX, 32'h00123456, st);
    acc(32'h14, 1'b0);
    acc(32'hf9, 1'b1);
    acc(32'h39, 1'b0);
    cmd(OP_WRSEED, 4'h1, 32'h00000001, st);
    chk("seed locked", 32'(st[9]), 32'h0);
    cmd(OP_WRPW, 4'h2, 32'h00abcdef, st);
    chk("other set refused", 32'(st[9]), 32'h0);
    cmd(OP_WRPW, 4'he, 32'h00abcdef, st);
    chk("own set write", 32'(st[9]), 32'h1);
    cmd(OP_VERIFY, 4'he, 32'h00abcdef, st);
    chk("new password", 32'(st[9]), 32'h1);
    blow(4'h0, 4'h8, st);
    $display("test fuses done");
    close_out();
  end
endmodule // tb_sca_top
